/* File: shared/itd_params.svh */
// timing counts and register map of the tap delay controller
`ifndef ITD_PARAMS_SVH
`define ITD_PARAMS_SVH
`define ITD_TAP_W 9
`define ITD_TAPS 512
`define ITD_SETTLE_CYC 10
`define ITD_LOAD_GAP_CYC 5
`define ITD_REG_CTRL 4'h0
`define ITD_REG_VALUE 4'h4
`define ITD_REG_STATUS 4'h8
`define ITD_REG_TAP 4'hc
`define ITD_CTRL_GO 0
`define ITD_CTRL_LOAD 1
`define ITD_CTRL_DIR 2
`define ITD_CTRL_TIME 3
`endif

/* File: shared/itd_pkg.sv */
// types of the tap delay controller
package itd_pkg;
   typedef logic [8:0] itd_tap_t;
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_WAIT_DLY = 4'h1,
      ST_WAIT_VTC = 4'h2,
      ST_IDLE = 4'h3,
      ST_PRE = 4'h4,
      ST_CAPTURE = 4'h5,
      ST_PRESENT = 4'h6,
      ST_PULSE = 4'h7,
      ST_STEP = 4'h8,
      ST_GAP = 4'h9,
      ST_POST = 4'ha
   } itd_state_e;
   typedef struct packed {
      logic load;
      logic ce;
      logic inc;
      logic lane_vtc;
      logic nibble_vtc;
      itd_tap_t value;
   } itd_lane_ctl_s;
endpackage

/* File: src/itd_ctrl.sv */
// host controller sequencing steps and loads into one lane input delay
//
// Chosen here: the Avalon-MM register port and the register addresses.
`include "itd_params.svh"
module itd_ctrl #(
   parameter int SETTLE = `ITD_SETTLE_CYC,
   parameter int GAP = `ITD_LOAD_GAP_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // avalon slave
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // nibble controller and lane
   input wire logic i_delay_ready,
   input wire logic i_compensation_ready,
   input wire itd_pkg::itd_tap_t i_tap_value_output,
   output itd_pkg::itd_lane_ctl_s o_lane
);
   import itd_pkg::*;

   itd_state_e state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic time_reg, dir_reg, load_mode_reg, busy_req_reg;
   itd_tap_t value_reg, tap_seen_reg, tap_sync1_reg, tap_sync2_reg;
   logic dly_s1_reg, dly_s2_reg, vtc_s1_reg, vtc_s2_reg;
   itd_lane_ctl_s lane_reg, lane_next;
   logic [31:0] rdata_reg;
   logic rd_ack_reg;

   // register map decode
   wire sel_ctrl = (i_address == `ITD_REG_CTRL);
   wire sel_value = (i_address == `ITD_REG_VALUE);
   wire sel_status = (i_address == `ITD_REG_STATUS);
   wire sel_tap = (i_address == `ITD_REG_TAP);
   wire wr_ctrl = i_write && sel_ctrl;
   wire wr_value = i_write && sel_value;
   wire go = wr_ctrl && i_writedata[`ITD_CTRL_GO];
   wire in_idle = (state_reg == ST_IDLE);
   wire cnt_done = (cnt_reg == 4'h0);
   // format changed while idle: startup handshake must run again
   wire fmt_stale = (time_reg != lane_reg.nibble_vtc);
   // vtc readiness only waited for in time format
   wire ready_ok = time_reg ? dly_s2_reg : 1'b1;
   wire vtc_ok = time_reg ? vtc_s2_reg : 1'b1;
   // one wait state on reads so the registered word stands when accepted
   wire rd_first = i_read && !rd_ack_reg;
   wire [31:0] ctrl_w = {28'h0, time_reg, dir_reg, load_mode_reg, 1'b0};
   wire [31:0] value_w = {23'h0, value_reg};
   wire [31:0] status_w = {27'h0, busy_req_reg, vtc_s2_reg, dly_s2_reg, in_idle, time_reg};
   wire [31:0] tap_w = {23'h0, tap_seen_reg};
   wire [31:0] rd_mux =
      sel_ctrl ? ctrl_w :
      sel_value ? value_w :
      sel_status ? status_w :
      sel_tap ? tap_w : 32'h0;

   assign o_waitrequest = rd_first;
   assign o_readdata = rdata_reg;
   assign o_lane = lane_reg;

   // lane signals cross in from another logic region; two flops first
   always_ff @(posedge i_mclk) begin
      dly_s1_reg <= i_delay_ready;
      dly_s2_reg <= dly_s1_reg;
      vtc_s1_reg <= i_compensation_ready;
      vtc_s2_reg <= vtc_s1_reg;
      tap_sync1_reg <= i_tap_value_output;
      tap_sync2_reg <= tap_sync1_reg;
   end

   // control fields refused while a sequence runs
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         time_reg <= 1'b0;
         dir_reg <= 1'b0;
         load_mode_reg <= 1'b0;
      end else if (wr_ctrl && in_idle) begin
         time_reg <= i_writedata[`ITD_CTRL_TIME];
         dir_reg <= i_writedata[`ITD_CTRL_DIR];
         load_mode_reg <= i_writedata[`ITD_CTRL_LOAD];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         value_reg <= '0;
      end else if (wr_value) begin
         value_reg <= i_writedata[8:0];
      end
   end

   // word latched on the first read cycle, held through the accepting edge
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rd_ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         rd_ack_reg <= rd_first;
         if (rd_first) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // request flag: set by go in idle, cleared when sequence starts
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         busy_req_reg <= 1'b0;
      end else if (go && in_idle) begin
         busy_req_reg <= 1'b1;
      end else if (state_reg == ST_PRE) begin
         busy_req_reg <= 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_done ? 4'h0 : cnt_reg - 4'h1;
      lane_next = lane_reg;
      lane_next.load = 1'b0;
      lane_next.ce = 1'b0;
      lane_next.inc = 1'b0;
      unique case (state_reg)
         ST_RESET: begin
            lane_next.lane_vtc = 1'b0;
            state_next = ST_WAIT_DLY;
         end
         ST_WAIT_DLY: begin
            if (ready_ok) begin
               lane_next.nibble_vtc = time_reg;
               state_next = ST_WAIT_VTC;
            end
         end
         ST_WAIT_VTC: begin
            if (vtc_ok) begin
               lane_next.lane_vtc = time_reg;
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (go) begin
               lane_next.lane_vtc = 1'b0;
               cnt_next = 4'(SETTLE - 1);
               state_next = ST_PRE;
            end else if (fmt_stale) begin
               // lane enable drops first, then the nibble handshake reruns
               lane_next.lane_vtc = 1'b0;
               state_next = ST_WAIT_DLY;
            end
         end
         ST_PRE: begin
            if (cnt_done) begin
               state_next = load_mode_reg ? ST_CAPTURE : ST_STEP;
            end
         end
         ST_CAPTURE: begin
            lane_next.value = value_reg;
            state_next = ST_PRESENT;
         end
         ST_PRESENT: begin
            lane_next.load = 1'b1;
            state_next = ST_PULSE;
         end
         ST_PULSE: begin
            cnt_next = 4'(GAP - 1);
            state_next = ST_GAP;
         end
         ST_STEP: begin
            lane_next.ce = 1'b1;
            lane_next.inc = dir_reg;
            // full settle count counted from the cycle after the strobe
            cnt_next = 4'(SETTLE);
            state_next = ST_POST;
         end
         ST_GAP: begin
            if (cnt_done) begin
               cnt_next = 4'(SETTLE - 2);
               state_next = ST_POST;
            end
         end
         ST_POST: begin
            if (cnt_done) begin
               // never raised before the nibble handshake has run
               lane_next.lane_vtc = time_reg && lane_reg.nibble_vtc;
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_RESET;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         state_reg <= ST_RESET;
         cnt_reg <= 4'h0;
         lane_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         lane_reg <= lane_next;
      end
   end

   // tap snapshot followed every idle cycle and taken once more as the pre-strobe settle wait ends
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         tap_seen_reg <= '0;
      end else if ((state_reg == ST_PRE && cnt_done) || state_reg == ST_IDLE) begin
         tap_seen_reg <= tap_sync2_reg;
      end
   end
endmodule

/* File: tb/itd_ctrl_properties.sv */
// assertions on the lane controls of the tap delay controller
module itd_chk (
   // watched ports
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_delay_ready,
   input wire logic i_compensation_ready,
   input wire itd_pkg::itd_lane_ctl_s o_lane
);
   timeunit 1ns;
   timeprecision 1ps;
   import itd_pkg::*;
   logic [4:0] quiet_reg;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // cycles since the last load or step, saturating
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) quiet_reg <= 5'h1f;
      else if (o_lane.load || o_lane.ce) quiet_reg <= 5'h00;
      else if (quiet_reg != 5'h1f) quiet_reg <= quiet_reg + 5'h01;
   end
   property p_load_vtc; o_lane.load |-> !o_lane.lane_vtc; endproperty
   a_load_vtc: assert property (p_load_vtc) else $error("load with enable high");
   property p_ce_vtc; o_lane.ce |-> !o_lane.lane_vtc; endproperty
   a_ce_vtc: assert property (p_ce_vtc) else $error("step with enable high");
   property p_inc_vtc; o_lane.inc |-> !o_lane.lane_vtc; endproperty
   a_inc_vtc: assert property (p_inc_vtc) else $error("direction with enable high");
   property p_lane_nib; o_lane.lane_vtc |-> o_lane.nibble_vtc; endproperty
   a_lane_nib: assert property (p_lane_nib) else $error("lane enable without nibble");
   property p_pre; (o_lane.load || o_lane.ce) |-> $past(o_lane.lane_vtc, 10) == 1'b0; endproperty
   a_pre: assert property (p_pre) else $error("too soon after enable low");
   property p_pulse; o_lane.load |=> !o_lane.load; endproperty
   a_pulse: assert property (p_pulse) else $error("load longer than one cycle");
   property p_present; o_lane.load |-> $stable(o_lane.value); endproperty
   a_present: assert property (p_present) else $error("value not presented early");
   property p_gap; o_lane.load |=> !o_lane.load [*5]; endproperty
   a_gap: assert property (p_gap) else $error("loads too close");
   property p_post; $rose(o_lane.lane_vtc) |-> quiet_reg >= 5'h0a; endproperty
   a_post: assert property (p_post) else $error("enable raised too soon");
   property p_nib; $rose(o_lane.nibble_vtc) |-> $past(i_delay_ready, 2); endproperty
   a_nib: assert property (p_nib) else $error("nibble enable before ready");
   property p_lane; $rose(o_lane.lane_vtc) |-> $past(i_compensation_ready, 2); endproperty
   a_lane: assert property (p_lane) else $error("lane enable before ready");
endmodule
bind itd_ctrl itd_chk u_chk (.i_mclk, .i_rst_b, .i_delay_ready, .i_compensation_ready, .o_lane);

/* File: tb/itd_lane_model.sv */
// behavioural input delay lane with its nibble ready flags
module itd_lane_model #(
   parameter int RDY_DLY = 20,
   parameter itd_pkg::itd_tap_t PRESET = 9'h000
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // lane controls
   input wire itd_pkg::itd_lane_ctl_s i_lane,
   // readiness and tap readback
   output logic o_delay_ready,
   output logic o_compensation_ready,
   output itd_pkg::itd_tap_t o_tap
);
   timeunit 1ns;
   timeprecision 1ps;
   import itd_pkg::*;
   int cnt;
   always @(posedge i_mclk) begin
      if (!i_rst_b) begin
         cnt <= 0;
         o_delay_ready <= 1'b0;
         o_compensation_ready <= 1'b0;
         o_tap <= PRESET;
      end else begin
         cnt <= cnt + 1;
         o_delay_ready <= cnt >= RDY_DLY;
         // no drift modelled, so compensation is a flag only
         o_compensation_ready <= i_lane.nibble_vtc && o_delay_ready;
         if (i_lane.load) o_tap <= i_lane.value;
         else if (i_lane.ce) o_tap <= i_lane.inc ? o_tap + 9'h001 : o_tap - 9'h001;
      end
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the tap delay controller
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import itd_pkg::*;
   logic i_mclk, i_rst_b, i_read, i_write, o_waitrequest, i_delay_ready, i_compensation_ready;
   logic cmp_rd;
   logic [3:0] i_address;
   logic [31:0] i_writedata, o_readdata, d;
   itd_tap_t i_tap_value_output, v;
   itd_lane_ctl_s o_lane;
   logic [31:0] q[$];
   int mismatches, checks;
   itd_ctrl dut (.i_mclk, .i_rst_b, .i_address, .i_read, .i_write, .i_writedata, .o_readdata,
      .o_waitrequest, .i_delay_ready, .i_compensation_ready, .i_tap_value_output, .o_lane);
   itd_lane_model dev (.i_mclk, .i_rst_b, .i_lane(o_lane), .o_delay_ready(i_delay_ready),
      .o_compensation_ready(i_compensation_ready), .o_tap(i_tap_value_output));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // read data stand at the edge that accepts the read
   always @(posedge i_mclk) begin
      if (i_read === 1'b1 && o_waitrequest === 1'b0 && cmp_rd === 1'b1) begin
         chk("readdata", o_readdata, q.pop_front());
      end
   end
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
         input logic c, input logic [31:0] e);
      int n;
      n = 0;
      if (c) q.push_back(e);
      @(posedge i_mclk);
      cmp_rd <= c;
      i_write <= w;
      i_read <= !w;
      i_address <= a;
      i_writedata <= wd;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 50);
      d = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      cmp_rd <= 1'b0;
      if (o_waitrequest !== 1'b0) begin
         mismatches++;
         finish_test;
      end
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 100; k++) begin
         bus(1'b0, 4'h8, 32'h0, 1'b0, 32'h0);
         if (d[1] === 1'b1) return;
      end
      mismatches++;
      finish_test;
   endtask
   task automatic op(input logic [31:0] ctl, input itd_tap_t t, input itd_tap_t e);
      bus(1'b1, 4'h4, {23'h0, t}, 1'b0, 32'h0);
      bus(1'b1, 4'h0, ctl, 1'b0, 32'h0);
      wait_idle;
      bus(1'b0, 4'hc, 32'h0, 1'b1, {23'h0, e});
   endtask
   initial begin
      {i_rst_b, i_read, i_write, cmp_rd, i_address, i_writedata} = '0;
      mismatches = 0;
      checks = 0;
      void'($urandom(32'h33f3));
      repeat (4) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      wait_idle;
      for (int k = 0; k < 4; k++) begin
         v = itd_tap_t'($urandom_range(510, 1));
         op(32'h3, v, v);
      end
      op(32'h5, 9'h000, v + 9'h001);
      op(32'h1, 9'h1ff, v);
      op(32'h3, 9'h1ff, 9'h1ff);
      op(32'h1, 9'h000, 9'h1fe);
      op(32'h3, 9'h000, 9'h000);
      // a second go while busy must be ignored
      bus(1'b1, 4'h4, 32'h0aa, 1'b0, 32'h0);
      bus(1'b1, 4'h0, 32'h3, 1'b0, 32'h0);
      bus(1'b1, 4'h0, 32'h5, 1'b0, 32'h0);
      wait_idle;
      bus(1'b0, 4'hc, 32'h0, 1'b1, 32'h0aa);
      bus(1'b0, 4'h8, 32'h0, 1'b1, 32'h6);
      bus(1'b0, 4'h2, 32'h0, 1'b1, 32'h0);
      chk("lane_vtc", o_lane.lane_vtc, 32'h0);
      // switch to time format: nibble handshake, then lane enable high
      bus(1'b1, 4'h0, 32'h8, 1'b0, 32'h0);
      wait_idle;
      chk("lane_vtc", o_lane.lane_vtc, 32'h1);
      bus(1'b0, 4'h8, 32'h0, 1'b1, 32'hf);
      op(32'hd, 9'h000, 9'h0ab);
      v = itd_tap_t'($urandom_range(510, 1));
      op(32'hb, v, v);
      chk("lane_vtc", o_lane.lane_vtc, 32'h1);
      @(posedge i_mclk);
      chk("pending", q.size(), 32'h0);
      finish_test;
   end
endmodule
